// File: rtl/uart_pkg.sv
package uart_pkg;
  // Register indices; byte address is four times the index
  localparam int unsigned IDX_DATA    = 0;
  localparam int unsigned IDX_IEN     = 1;
  localparam int unsigned IDX_IID     = 2;
  localparam int unsigned IDX_LCR     = 3;
  localparam int unsigned IDX_MCR     = 4;
  localparam int unsigned IDX_LSR     = 5;
  localparam int unsigned IDX_MSR     = 6;
  localparam int unsigned IDX_SCR     = 7;
  localparam int unsigned IDX_ISTAT   = 8;
  localparam int unsigned IDX_IMASK   = 9;
  localparam int unsigned IDX_MODE    = 10;
  localparam int unsigned IDX_SHADOW0 = 32;
  localparam int unsigned IDX_SHADOW1 = 33;
  // Field positions
  localparam int unsigned LCR_DIVISOR_ACCESS_BIT  = 7;
  localparam int unsigned LCR_PEN   = 3;
  localparam int unsigned LCR_STB   = 2;
  localparam int unsigned LCR_EPS   = 4;
  localparam int unsigned LCR_STICK = 5;
  localparam int unsigned LCR_BRK   = 6;
  localparam int unsigned FCR_EN    = 0;
  localparam int unsigned FCR_RXRST = 1;
  localparam int unsigned FCR_TXRST = 2;
  localparam int unsigned MCR_LOOP  = 4;
  // Reset values
  localparam logic [7:0] IID_RESET = 8'h01;
  localparam logic [7:0] LSR_RESET = 8'h60;
  // Identification codes, interrupt ident bits 3:1
  localparam logic [2:0] ID_LINE  = 3'h3;
  localparam logic [2:0] ID_RXAV  = 3'h2;
  localparam logic [2:0] ID_TOUT  = 3'h6;
  localparam logic [2:0] ID_HOLDING_EMPTY  = 3'h1;
  localparam logic [2:0] ID_MODEM = 3'h0;
  // Sixteen samples per bit; timeout after four ten-bit characters
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID  = 4'h7;
  localparam int unsigned TOUT_CHARS = 4;
  localparam int unsigned CHAR_BITS  = 10;
  localparam logic [9:0] TOUT_TICKS = 10'(TOUT_CHARS * CHAR_BITS * 16);
  // Receive trigger levels for codes 0..3
  localparam logic [4:0] TRIG0 = 5'h01;
  localparam logic [4:0] TRIG1 = 5'h04;
  localparam logic [4:0] TRIG2 = 5'h08;
  localparam logic [4:0] TRIG3 = 5'h0e;
endpackage

// File: rtl/uart_channel.sv
// Behaviour
// - Line control bit 7 maps divisor at 0/1
// - Bit 0 shifted first, both directions
// - Legacy mode: tx-all-empty follows shift register
// - Legacy mode hides the scratch byte
// - No FIFOs: ident 3,6,7 and status 7 zero
// - DMA mode bit writes are ignored
// - FIFO control writes copied to shadow
// - Receive FIFO holds DEPTH bytes, one with FIFOs off
// - Ident read-only; bit0 low when pending
// - Address 0: write transmits, read receives
// - FIFO control: enable, resets, trigger level
// - Aux outputs stored, drive no pin
// - Ident resets to 0x01
// - Line status resets to 0x60
// - Data ready while receive FIFO nonempty
`timescale 1ns/10ps
`default_nettype none
module uart_channel #(
  parameter int unsigned AW    = 12,
  parameter int unsigned DEPTH = 16,
  parameter bit          CHAN  = 1'b0
) (
  // APB slave
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Serial line
  input  wire logic          rxd,
  output logic               txd,
  // Modem lines, active low
  input  wire logic          cts_n,
  input  wire logic          dsr_n,
  input  wire logic          ri_n,
  input  wire logic          dcd_n,
  output logic               dtr_n,
  output logic               rts_n,
  // Interrupt
  output logic               irq
);
  localparam int unsigned PW = $clog2(DEPTH);

  // Counters must hold DEPTH exactly; the shadow index needs eight address bits
  if (DEPTH < 2 || DEPTH > 16 || (DEPTH & (DEPTH - 1)) != 0 || AW < 8) begin : g_chk
    $error("DEPTH must be a power of two from 2 to 16 and AW at least 8");
  end

  logic [7:0]  ien_q, lcr_q, mcr_q, scr_q, dll_q, dlm_q;  // Software registers
  logic [7:0]  fcr_q, shadow_q, imask_q, istat_q;
  logic        legacy_q;                       // legacy_pc_mode
  logic        pready_q, pslverr_q, irq_q, txo_q, dtr_n_q, rts_n_q;
  logic [31:0] prdata_q;
  logic [PW:0] tx_cnt_q, rx_cnt_q;             // FIFO fill levels
  logic [PW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [7:0]  tx_mem [DEPTH];                 // Transmit FIFO
  logic [10:0] rx_mem [DEPTH];                 // {break, frame, parity, data}
  logic [3:0]  err_q;                          // {break, frame, parity, overrun}
  logic [3:0]  msd_q, mprev_q;                 // Modem deltas, last inputs
  logic        holding_empty_q, tout_q;
  logic [9:0]  tout_cnt_q;
  logic [15:0] bcnt_q;                         // Baud prescaler

  // Bus phases: pready rises on the second access cycle
  logic acc, setup_rd, done, wr, rd, mapped, divisor_access_bit, fifo_en, tick;
  logic [AW-3:0] idx;
  assign acc      = psel & penable;
  assign setup_rd = acc & ~pready_q;
  assign done     = acc & pready_q;
  assign wr       = done & pwrite;
  assign rd       = done & ~pwrite;
  assign idx      = paddr[AW-1:2];
  assign divisor_access_bit     = lcr_q[uart_pkg::LCR_DIVISOR_ACCESS_BIT];
  assign fifo_en  = fcr_q[uart_pkg::FCR_EN];
  assign mapped   = idx <= (AW-2)'(uart_pkg::IDX_MODE)
                 || idx == (AW-2)'(CHAN ? uart_pkg::IDX_SHADOW1 : uart_pkg::IDX_SHADOW0);

  // Common strobes
  logic wdat, rdat, wfcr, tx_full, rx_lim, rx_push, tx_pop;
  logic [PW:0] lim;
  assign wdat = wr & idx == (AW-2)'(uart_pkg::IDX_DATA) & ~divisor_access_bit;
  assign rdat = rd & idx == (AW-2)'(uart_pkg::IDX_DATA) & ~divisor_access_bit;
  assign wfcr = wr & idx == (AW-2)'(uart_pkg::IDX_IID);
  // Without FIFOs each direction holds a single byte
  assign lim     = fifo_en ? (PW+1)'(DEPTH) : (PW+1)'(1);
  assign tx_full = tx_cnt_q >= lim;

  // Line status and interrupt ident, both combinational views
  logic [7:0] line_status, interrupt_ident, modem_status;
  logic       tx_busy_q, pend;
  logic [2:0] code;
  logic [4:0] trig;
  always_comb begin
    line_status = {fifo_en & |err_q[3:1], tx_cnt_q == '0 & ~tx_busy_q, tx_cnt_q == '0,
           err_q, rx_cnt_q != '0};
    if (legacy_q) line_status[6] = ~tx_busy_q;
    unique case (fcr_q[7:6])
      2'd0: trig = uart_pkg::TRIG0;
      2'd1: trig = uart_pkg::TRIG1;
      2'd2: trig = uart_pkg::TRIG2;
      2'd3: trig = uart_pkg::TRIG3;
    endcase
    pend = 1'b1;
    // Priority: line, receive, timeout, holding empty, modem
    if (ien_q[2] & |err_q) code = uart_pkg::ID_LINE;
    else if (ien_q[0] & (fifo_en ? 5'(rx_cnt_q) >= trig : rx_cnt_q != '0))
      code = uart_pkg::ID_RXAV;
    else if (ien_q[0] & fifo_en & tout_q) code = uart_pkg::ID_TOUT;
    else if (ien_q[1] & holding_empty_q) code = uart_pkg::ID_HOLDING_EMPTY;
    else if (ien_q[3] & |msd_q) code = uart_pkg::ID_MODEM;
    else begin
      code = 3'h0;
      pend = 1'b0;
    end
    interrupt_ident = {fifo_en, fifo_en, 2'b00, code, ~pend};
    modem_status = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n, msd_q};
  end

  // Read data mux
  logic [7:0] rmux;
  always_comb begin
    unique case (idx)
      (AW-2)'(uart_pkg::IDX_DATA):  rmux = divisor_access_bit ? dll_q : rx_mem[rx_rp_q][7:0];
      (AW-2)'(uart_pkg::IDX_IEN):   rmux = divisor_access_bit ? dlm_q : ien_q;
      (AW-2)'(uart_pkg::IDX_IID):   rmux = interrupt_ident;
      (AW-2)'(uart_pkg::IDX_LCR):   rmux = lcr_q;
      (AW-2)'(uart_pkg::IDX_MCR):   rmux = mcr_q;
      (AW-2)'(uart_pkg::IDX_LSR):   rmux = line_status;
      (AW-2)'(uart_pkg::IDX_MSR):   rmux = modem_status;
      (AW-2)'(uart_pkg::IDX_SCR):   rmux = legacy_q ? 8'h00 : scr_q;
      (AW-2)'(uart_pkg::IDX_ISTAT): rmux = istat_q;
      (AW-2)'(uart_pkg::IDX_IMASK): rmux = imask_q;
      (AW-2)'(uart_pkg::IDX_MODE):  rmux = {7'h00, legacy_q};
      default:                      rmux = mapped ? shadow_q : 8'h00;
    endcase
  end

  // APB answer; data is held so read side effects clear only what was seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup_rd;
      pslverr_q <= setup_rd & ~mapped;
      if (setup_rd & ~pwrite) prdata_q <= {24'h00_0000, rmux};
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ien_q, lcr_q, mcr_q, scr_q, dll_q, dlm_q} <= '0;
      {fcr_q, shadow_q, imask_q} <= '0;
      legacy_q <= 1'b0;
    end else if (wr) begin
      unique case (idx)
        (AW-2)'(uart_pkg::IDX_DATA): if (divisor_access_bit) dll_q <= pwdata[7:0];
        (AW-2)'(uart_pkg::IDX_IEN):
          if (divisor_access_bit) dlm_q <= pwdata[7:0];
          else ien_q <= {4'h0, pwdata[3:0]};
        (AW-2)'(uart_pkg::IDX_IID): begin
          // Reset bits self-clear, DMA select and reserved bits never stick
          fcr_q <= {pwdata[7:6], 5'h00, pwdata[uart_pkg::FCR_EN]};
        end
        (AW-2)'(uart_pkg::IDX_LCR):   lcr_q <= pwdata[7:0];
        (AW-2)'(uart_pkg::IDX_MCR):   mcr_q <= {3'h0, pwdata[4:0]};
        (AW-2)'(uart_pkg::IDX_SCR):   if (!legacy_q) scr_q <= pwdata[7:0];
        (AW-2)'(uart_pkg::IDX_IMASK): imask_q <= {4'h0, pwdata[3:0]};
        (AW-2)'(uart_pkg::IDX_MODE):  legacy_q <= pwdata[0];
        default: ;
      endcase
      if (wfcr) shadow_q <= pwdata[7:0];
    end
  end

  // Baud prescaler, one tick per sixteenth of a bit
  assign tick = bcnt_q == 16'h0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bcnt_q <= 16'h0000;
    // A divisor write restarts the count, else a stale long count delays the new rate
    else if (wr & divisor_access_bit & idx <= (AW-2)'(uart_pkg::IDX_IEN)) bcnt_q <= 16'h0000;
    else bcnt_q <= tick ? {dlm_q, dll_q} - 16'h0001 : bcnt_q - 16'h0001;
  end

  // Frame length from line control: start, data, parity, stop(s)
  logic [3:0] nd, nbits;
  assign nd    = 4'd5 + {2'b00, lcr_q[1:0]};
  assign nbits = nd + {3'h0, lcr_q[uart_pkg::LCR_PEN]} + 4'd2
               + {3'h0, lcr_q[uart_pkg::LCR_STB]};

  // Parity for the low nd bits of a byte under current line control
  function automatic logic par_of(input logic [7:0] d, input logic [7:0] lc, input logic [3:0] n);
    logic p;
    p = 1'b0;
    for (int i = 0; i < 8; i++) if (4'(i) < n) p ^= d[i];
    if (lc[uart_pkg::LCR_STICK]) par_of = ~lc[uart_pkg::LCR_EPS];
    else par_of = lc[uart_pkg::LCR_EPS] ? p : ~p;
  endfunction

  // Transmit FIFO and shifter; frame bits after the start bit sit LSB first
  logic [10:0] tx_sh_q, frame;
  logic [3:0]  tx_left_q, tx_sub_q;
  logic        tx_line_q;
  always_comb begin
    frame = 11'h7ff;
    for (int i = 0; i < 8; i++) if (4'(i) < nd) frame[i] = tx_mem[tx_rp_q][i];
    if (lcr_q[uart_pkg::LCR_PEN]) frame[nd] = par_of(tx_mem[tx_rp_q], lcr_q, nd);
  end
  assign tx_pop = tick & ~tx_busy_q & tx_cnt_q != '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {tx_wp_q, tx_rp_q, tx_cnt_q} <= '0;
    end else if (wfcr & pwdata[uart_pkg::FCR_TXRST]) begin
      {tx_wp_q, tx_rp_q, tx_cnt_q} <= '0;
    end else begin
      // A full FIFO drops the write rather than overwrite queued data
      if (wdat & ~tx_full) begin
        tx_mem[tx_wp_q] <= pwdata[7:0];
        tx_wp_q         <= tx_wp_q + 1'b1;
      end
      if (tx_pop) tx_rp_q <= tx_rp_q + 1'b1;
      tx_cnt_q <= tx_cnt_q + (PW+1)'(wdat & ~tx_full) - (PW+1)'(tx_pop);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy_q <= 1'b0;
      tx_line_q <= 1'b1;
      tx_sh_q   <= 11'h7ff;
      tx_left_q <= 4'h0;
      tx_sub_q  <= 4'h0;
    end else if (tx_pop) begin
      tx_busy_q <= 1'b1;
      tx_line_q <= 1'b0;
      tx_sh_q   <= frame;
      tx_left_q <= nbits - 4'd1;
      tx_sub_q  <= uart_pkg::OVS_LAST;
    end else if (tick & tx_busy_q) begin
      if (tx_sub_q != 4'h0) tx_sub_q <= tx_sub_q - 4'h1;
      else if (tx_left_q == 4'h0) tx_busy_q <= 1'b0;
      else begin
        tx_line_q <= tx_sh_q[0];
        tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
        tx_left_q <= tx_left_q - 4'h1;
        tx_sub_q  <= uart_pkg::OVS_LAST;
      end
    end
  end

  // Receiver samples mid-bit; after a break it waits for the line to go idle
  logic        rx_in, rx_busy_q, rx_arm_q, rx_done;
  logic [11:0] rx_f_q;
  logic [3:0]  rx_pos_q, rx_sub_q;
  logic [7:0]  rdata;
  logic [2:0]  rerr;
  assign rx_in   = mcr_q[uart_pkg::MCR_LOOP] ? tx_line_q : rxd;
  assign rx_done = tick & rx_busy_q & rx_sub_q == 4'h0 & rx_pos_q == nbits - 4'd1
                 - {3'h0, lcr_q[uart_pkg::LCR_STB]};
  always_comb begin
    rdata = 8'h00;
    for (int i = 0; i < 8; i++) if (4'(i) < nd) rdata[i] = rx_f_q[i+1];
    // {break, framing, parity}; stop bit is the one just sampled
    rerr = {~rx_in & rx_f_q == 12'h000, ~rx_in,
            lcr_q[uart_pkg::LCR_PEN] & (rx_f_q[nd+1] != par_of(rdata, lcr_q, nd))};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rx_busy_q, rx_f_q, rx_pos_q, rx_sub_q} <= '0;
      rx_arm_q <= 1'b0;
    end else if (tick) begin
      if (!rx_busy_q) begin
        rx_arm_q <= rx_in | rx_arm_q;
        if (rx_arm_q & ~rx_in) begin
          {rx_busy_q, rx_f_q, rx_pos_q} <= {1'b1, 16'h0000};
          rx_sub_q <= uart_pkg::OVS_MID;
        end
      end else if (rx_sub_q != 4'h0) rx_sub_q <= rx_sub_q - 4'h1;
      else if (rx_pos_q == 4'h0 & rx_in) rx_busy_q <= 1'b0;  // False start
      else begin
        rx_f_q[rx_pos_q] <= rx_in;
        rx_pos_q <= rx_pos_q + 4'h1;
        rx_sub_q <= uart_pkg::OVS_LAST;
        if (rx_done) begin
          rx_busy_q <= 1'b0;
          rx_arm_q  <= rx_in;
        end
      end
    end
  end

  // Receive FIFO: with FIFOs on, depth stays DEPTH whatever trigger is set
  logic rx_pop;
  assign rx_lim  = rx_cnt_q >= lim;
  assign rx_push = rx_done & ~rx_lim;
  assign rx_pop  = rdat & rx_cnt_q != '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rx_wp_q, rx_rp_q, rx_cnt_q} <= '0;
    end else if (wfcr & pwdata[uart_pkg::FCR_RXRST]) begin
      {rx_wp_q, rx_rp_q, rx_cnt_q} <= '0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp_q] <= {rerr, rdata};
        rx_wp_q         <= rx_wp_q + 1'b1;
      end
      if (rx_pop) rx_rp_q <= rx_rp_q + 1'b1;
      rx_cnt_q <= rx_cnt_q + (PW+1)'(rx_push) - (PW+1)'(rx_pop);
    end
  end

  // Sticky line errors; a read clears only bits it returned, new errors win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) err_q <= 4'h0;
    else err_q <= (err_q & ~((rd & idx == (AW-2)'(uart_pkg::IDX_LSR)) ? prdata_q[4:1] : 4'h0))
                | (rx_done ? {rerr, rx_lim} : 4'h0);
  end

  // Modem deltas and holding-empty flag
  logic holding_empty_set;
  // A write in the emptying cycle blocks the flag; it refills the FIFO only with FIFOs on
  assign holding_empty_set = tx_cnt_q != '0 & tx_cnt_q - (PW+1)'(tx_pop) == '0 & ~wdat;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msd_q   <= 4'h0;
      mprev_q <= 4'h0;
      holding_empty_q  <= 1'b0;
    end else begin
      mprev_q <= {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
      msd_q   <= (msd_q & ~((rd & idx == (AW-2)'(uart_pkg::IDX_MSR)) ? prdata_q[3:0] : 4'h0))
               | {mprev_q[3] ^ ~dcd_n, mprev_q[2] & ri_n, mprev_q[1] ^ ~dsr_n,
                  mprev_q[0] ^ ~cts_n};
      // Cleared by a data write or by an ident read that reported it
      holding_empty_q  <= holding_empty_set | (holding_empty_q & ~wdat & ~(rd & idx == (AW-2)'(uart_pkg::IDX_IID)
               & prdata_q[3:1] == uart_pkg::ID_HOLDING_EMPTY & ~prdata_q[0]));
    end
  end

  // Character timeout, restarted by any push or pop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tout_cnt_q <= 10'h000;
      tout_q     <= 1'b0;
    end else if (rx_push | rx_pop | rx_cnt_q == '0) begin
      tout_cnt_q <= 10'h000;
      tout_q     <= 1'b0;
    end else if (tick & ~tout_q) begin
      tout_cnt_q <= tout_cnt_q + 10'h001;
      tout_q     <= tout_cnt_q == uart_pkg::TOUT_TICKS - 10'h001;
    end
  end

  // Event status, read-to-clear with set winning, masked onto irq
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) istat_q <= 8'h00;
    else istat_q <= (istat_q & ~((rd & idx == (AW-2)'(uart_pkg::IDX_ISTAT)) ? prdata_q[7:0] : 8'h00))
                  | {4'h0, msd_q != 4'h0, rx_done & (|rerr | rx_lim), holding_empty_set, rx_push};
  end

  // Output flops; aux bits 2 and 3 deliberately reach no pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q   <= 1'b0;
      txo_q   <= 1'b1;
      dtr_n_q <= 1'b1;
      rts_n_q <= 1'b1;
    end else begin
      irq_q   <= |(istat_q & imask_q);
      txo_q   <= tx_line_q & ~lcr_q[uart_pkg::LCR_BRK];
      dtr_n_q <= ~mcr_q[0];
      rts_n_q <= ~mcr_q[1];
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign txd     = txo_q;
  assign irq     = irq_q;
  assign dtr_n   = dtr_n_q;
  assign rts_n   = rts_n_q;

  a_divisor_access_bit_low_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup_rd && !pwrite && idx == '0 && divisor_access_bit |=> prdata_q[7:0] == $past(dll_q))
    else $error("divisor low not returned");
  a_tx_lsb_first: assert property (@(posedge pclk) disable iff (!presetn)
    tx_pop |=> tx_sh_q[0] == $past(tx_mem[tx_rp_q][0]) && !tx_line_q)
    else $error("transmit not lsb first");
  a_legacy_tx_all_empty: assert property (@(posedge pclk) disable iff (!presetn)
    legacy_q && !tx_busy_q |-> line_status[6])
    else $error("tx-all-empty low with idle shifter");
  a_scratch_hidden: assert property (@(posedge pclk) disable iff (!presetn)
    setup_rd && !pwrite && idx == (AW-2)'(uart_pkg::IDX_SCR) && legacy_q
    |=> prdata_q == 32'h0000_0000)
    else $error("scratch visible in legacy mode");
  a_nofifo_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !fifo_en |-> interrupt_ident[7:6] == 2'b00 && !interrupt_ident[3] && !line_status[7])
    else $error("fifo-only bits set without fifos");
  a_fcr_shadow: assert property (@(posedge pclk) disable iff (!presetn)
    wfcr |=> shadow_q == $past(pwdata[7:0]) && !fcr_q[3])
    else $error("shadow missed or dma bit stuck");
  a_rx_depth: assert property (@(posedge pclk) disable iff (!presetn)
    rx_cnt_q == (PW+1)'(DEPTH) && rx_done && !rx_pop && !wfcr
    |=> rx_cnt_q == (PW+1)'(DEPTH) && err_q[0])
    else $error("receive fifo overfilled");
  a_data_ready: assert property (@(posedge pclk) disable iff (!presetn)
    fifo_en && !ien_q[0] && rx_cnt_q != '0 |-> line_status[0])
    else $error("data ready dropped");
endmodule
`default_nettype wire

// File: verif/uart_far_end.sv
`timescale 1ns/10ps
`default_nettype none
module uart_far_end #(
  parameter int BIT = 16  // pclk cycles per bit with a divisor of one
) (
  // Clock
  input  wire logic pclk,
  // Serial line
  input  wire logic txd,
  output logic      rxd,
  // Modem lines, active low
  output logic      cts_n,
  output logic      dsr_n,
  output logic      ri_n,
  output logic      dcd_n
);
  logic [7:0] got;    // Last byte taken off the channel's line
  int         n_got;  // Bytes taken so far
  logic [7:0] sh;     // Capture shift register

  // Idle line high, modem lines inactive
  initial begin
    rxd   = 1'b1;
    cts_n = 1'b1;
    dsr_n = 1'b1;
    ri_n  = 1'b1;
    dcd_n = 1'b1;
    n_got = 0;
  end

  // One frame, eight data bits, no parity, one stop; call right after an edge
  task automatic send_byte(input logic [7:0] v);
    rxd <= 1'b0;
    repeat (BIT) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      rxd <= v[i];
      repeat (BIT) @(posedge pclk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge pclk);
  endtask

  // Capture: sample mid-bit, bit 0 arrives first
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge pclk);
      sh[i] = txd;
    end
    repeat (BIT) @(posedge pclk);
    got = sh;
    n_got++;
  end
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        pclk;     // 50 MHz clock
  logic        presetn;  // Async reset, active low
  logic        psel;     // APB select
  logic        penable;  // APB access phase
  logic        pwrite;   // APB direction
  logic [11:0] paddr;    // APB byte address
  logic [31:0] pwdata;   // APB write data
  logic [31:0] prdata;   // APB read data
  logic        pready;   // APB answer
  logic        pslverr;  // APB error
  logic        rxd;      // Line into the channel
  logic        txd;      // Line out of the channel
  logic        cts_n;    // Modem inputs from the far end
  logic        dsr_n;
  logic        ri_n;
  logic        dcd_n;
  logic        dtr_n;    // Modem outputs
  logic        rts_n;
  logic        irq;      // Interrupt level
  int          n_errors;
  int          check_count;
  logic [31:0] rd;       // Last read word
  logic        err;      // Last pslverr seen
  int          k;

  uart_channel #(.AW(12), .DEPTH(16), .CHAN(1'b0)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n),
    .dtr_n(dtr_n), .rts_n(rts_n), .irq(irq));

  uart_far_end #(.BIT(16)) far (
    .pclk(pclk), .txd(txd), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
    .dcd_n(dcd_n));

  // Free-running clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Verdict, the single exit of the run
  task automatic final_report;
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compare seen against expected, four-state exact
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer by register index; entered and left just after an edge
  task automatic apb(input logic wr, input int idx, input logic [7:0] wd);
    int   n;
    logic ok;  // Answer as the coming rising edge samples it
    n = 0;
    ok = 1'b0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= 12'(idx * 4);
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // Outputs move only on rising edges, so mid-cycle values are what the edge sees
    do begin
      @(negedge pclk);
      ok  = pready;
      rd  = prdata;
      err = pslverr;
      n++;
      @(posedge pclk);
    end while (ok !== 1'b1 && n < 50);
    if (ok !== 1'b1) begin
      n_errors++;
      final_report();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);  // Idle cycle so no signal is assigned twice in a step
  endtask

  // Bounded wait for the far end to have taken cnt bytes
  task automatic wait_tx(input int cnt);
    int n;
    for (n = 0; n < 2000 && far.n_got < cnt; n++) @(posedge pclk);
    if (n >= 2000) begin
      n_errors++;
      final_report();
    end
  endtask

  initial begin
    n_errors = 0;
    check_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values
    apb(1'b0, uart_pkg::IDX_IID, 8'h00); chk(rd, 32'h00000001);
    apb(1'b0, uart_pkg::IDX_LSR, 8'h00); chk(rd, 32'h00000060);
    // Divisor overlay and width; interrupt enable hidden behind it
    apb(1'b1, uart_pkg::IDX_LCR, 8'h80);
    apb(1'b1, uart_pkg::IDX_IEN, 8'h5a);
    apb(1'b0, uart_pkg::IDX_IEN, 8'h00); chk(rd, 32'h0000005a);
    apb(1'b1, uart_pkg::IDX_IEN, 8'h00);
    apb(1'b1, uart_pkg::IDX_DATA, 8'h01);
    apb(1'b1, uart_pkg::IDX_LCR, 8'h03);
    apb(1'b1, uart_pkg::IDX_IEN, 8'h08);
    apb(1'b0, uart_pkg::IDX_IEN, 8'h00); chk(rd, 32'h00000008);
    apb(1'b0, uart_pkg::IDX_LCR, 8'h00); chk(rd, 32'h00000003);
    // Aux bits kept as storage, modem outputs follow bits 0 and 1
    apb(1'b1, uart_pkg::IDX_MCR, 8'h0f);
    apb(1'b0, uart_pkg::IDX_MCR, 8'h00); chk(rd, 32'h0000000f);
    chk({dtr_n, rts_n}, 2'b00);
    // Scratch byte hidden in legacy mode
    apb(1'b1, uart_pkg::IDX_SCR, 8'ha5);
    apb(1'b1, uart_pkg::IDX_MODE, 8'h01);
    apb(1'b1, uart_pkg::IDX_SCR, 8'h3c);
    apb(1'b0, uart_pkg::IDX_SCR, 8'h00); chk(rd, 32'h00000000);
    // Legacy mode: all-empty flag drops while shifting, returns after
    apb(1'b1, uart_pkg::IDX_DATA, 8'h5a);
    apb(1'b0, uart_pkg::IDX_LSR, 8'h00); chk(rd[6], 1'b0);
    wait_tx(1);
    chk(far.got, 8'h5a);
    repeat (40) @(posedge pclk);
    apb(1'b0, uart_pkg::IDX_LSR, 8'h00); chk(rd[6], 1'b1);
    apb(1'b1, uart_pkg::IDX_MODE, 8'h00);
    apb(1'b0, uart_pkg::IDX_SCR, 8'h00); chk(rd, 32'h000000a5);
    // FIFO control with the DMA bit set, copied raw to the shadow
    apb(1'b1, uart_pkg::IDX_IID, 8'hc9);
    apb(1'b0, uart_pkg::IDX_SHADOW0, 8'h00); chk(rd, 32'h000000c9);
    apb(1'b0, uart_pkg::IDX_IID, 8'h00); chk(rd[0], 1'b1);
    // Unmapped index refused
    apb(1'b0, 11, 8'h00); chk(rd, 32'h00000000);
    chk(err, 1'b1);
    // Seventeen bytes in: sixteen kept, overrun on the last
    apb(1'b1, uart_pkg::IDX_IMASK, 8'h01);
    for (k = 0; k < 17; k++) far.send_byte(8'(8'h10 + k));
    repeat (20) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b0, uart_pkg::IDX_LSR, 8'h00); chk(rd[1:0], 2'b11);
    for (k = 0; k < 16; k++) begin
      apb(1'b0, uart_pkg::IDX_DATA, 8'h00); chk(rd, 32'(8'h10 + k));
      if (k == 14) begin
        apb(1'b0, uart_pkg::IDX_LSR, 8'h00); chk(rd[0], 1'b1);
      end
    end
    apb(1'b0, uart_pkg::IDX_LSR, 8'h00); chk(rd[0], 1'b0);
    // Status read clears; masked events keep irq low
    apb(1'b0, uart_pkg::IDX_ISTAT, 8'h00); chk(rd[0], 1'b1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, uart_pkg::IDX_IMASK, 8'h00);
    far.send_byte(8'h81);
    repeat (20) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b0, uart_pkg::IDX_ISTAT, 8'h00); chk(rd[0], 1'b1);
    // FIFOs off: fifo bits of ident and status read zero
    apb(1'b1, uart_pkg::IDX_IID, 8'h00);
    apb(1'b0, uart_pkg::IDX_IID, 8'h00); chk(rd, 32'h00000001);
    apb(1'b0, uart_pkg::IDX_LSR, 8'h00); chk(rd[7], 1'b0);
    chk(rd[0], 1'b1);
    // Receive FIFO reset drops the byte still queued
    apb(1'b1, uart_pkg::IDX_IID, 8'h02);
    apb(1'b0, uart_pkg::IDX_LSR, 8'h00); chk(rd[0], 1'b0);
    final_report();
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    final_report();
  end
endmodule
`default_nettype wire
